// File: rtl/wwdt_top.sv
// Windowed watchdog timer with APB register access
//
// How it works
// [R1] The counter runs after reset only when the enable bit of the captured option byte is 1.
// [R2] The overflow time comes from the three-bit overflow period select field of the option byte.
// [R3] The open span of the window comes from the two-bit open span select field of the option byte.
// [R4] Writing the key before overflow clears the counter and counting restarts from zero.
// [R5] From the second refresh write on, a write during the closed window raises the internal reset.
// [R6] Reaching the overflow time with no valid key write raises the internal reset.
// [R7] A single-bit access to the refresh key register raises the internal reset.
// [R8] Writing any byte other than the key to the refresh key register raises the internal reset.
// [R9] The first refresh write after reset ignores the window and clears the counter if keyed.
// [R10] After a clear the overflow time deviates by at most two slow clock cycles.
// [R11] A key write at the last count before overflow still clears the counter.
// [R12] The counter steps on the slow oscillator clock and every reset returns all state to its start.
// [R13] Software writes the key as a full byte, inside the open window and before overflow.
//
// The APB register port is this design's own decision.
`include "wwdt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wwdt_top #(
    parameter int CNT_W = 15
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bit manipulation qualifier of the current write
    input  wire logic        bit_access,
    // Nonvolatile option byte
    input  wire logic [7:0]  option_byte_in,
    // Slow oscillator clock
    input  wire logic        slow_osc_clock,
    // Outputs
    output logic             irq,
    output logic             internal_rst
);

    // Overflow limit in ticks
    function automatic logic [CNT_W:0] ovf_limit(input logic [2:0] sel);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'b0}}, 1'b1};
        return one << (`WWDT_BASE_EXP + sel);
    endfunction

    // Register offset match
    function automatic logic addr_is(input logic [11:0] addr,
                                     input logic [11:0] ofs);
        return (addr == ofs);
    endfunction

    // First count of the open window
    function automatic logic [CNT_W:0] win_start(input logic [CNT_W:0] lim,
                                                 input logic [1:0]     sel);
        logic [CNT_W:0] res;
        res = {(CNT_W + 1){1'b0}};
        case (sel)
            `WWDT_WIN_25: res = lim - (lim >> 2);
            `WWDT_WIN_50: res = lim >> 1;
            `WWDT_WIN_75: res = lim >> 2;
            default:      res = {(CNT_W + 1){1'b0}};
        endcase
        return res;
    endfunction

    // State
    logic [7:0]       option_ff;
    logic             opt_loaded_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             first_done_ff;
    logic             fault_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;

    // Slow clock tick
    logic tick;

    wwdt_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (slow_osc_clock),
        .level_ff (),
        .rise_ff  (tick)
    );

    // Option byte fields
    wire       fuse_en   = option_ff[`WWDT_EN_BIT];
    wire [2:0] ovf_sel   = option_ff[`WWDT_OVF_HI:`WWDT_OVF_LO];
    wire [1:0] span_sel  = option_ff[`WWDT_WIN_HI:`WWDT_WIN_LO];

    wire [CNT_W:0] limit      = ovf_limit(ovf_sel);                     // see [R2]
    wire [CNT_W:0] open_from  = win_start(limit, span_sel);             // see [R3]
    wire [CNT_W:0] cnt_ext    = {1'b0, cnt_ff};
    wire           win_open   = (cnt_ext >= open_from);
    wire           at_last    = (cnt_ext == (limit - {{CNT_W{1'b0}}, 1'b1}));
    wire           running    = opt_loaded_ff & fuse_en & ~fault_ff;   // see [R1]

    // APB decode
    wire setup    = psel & ~penable;
    wire access   = psel & penable & pready_ff;
    wire wr_fire  = access & pwrite;
    wire hit_ref  = addr_is(paddr, `WWDT_OFS_REFRESH);
    wire hit_sts  = addr_is(paddr, `WWDT_OFS_STATUS);
    wire hit_msk  = addr_is(paddr, `WWDT_OFS_MASK);
    wire hit_cnt  = addr_is(paddr, `WWDT_OFS_COUNT);
    wire hit_opt  = addr_is(paddr, `WWDT_OFS_OPTION);
    wire mapped   = hit_ref | hit_sts | hit_msk | hit_cnt | hit_opt;
    wire ro_hit   = hit_cnt | hit_opt;
    wire bad_req  = ~mapped | (pwrite & ro_hit);

    wire ref_wr   = wr_fire & hit_ref & running;
    wire sts_wr   = wr_fire & hit_sts;
    wire msk_wr   = wr_fire & hit_msk;

    // Refresh verdict
    wire key_ok   = pstrb[0] & (pwdata[7:0] == `WWDT_KEY);
    wire ev_bit   = ref_wr & bit_access;                                // see [R7]
    wire ev_key   = ref_wr & ~bit_access & ~key_ok;                     // see [R8]
    wire ev_win   = ref_wr & ~bit_access & key_ok & first_done_ff & ~win_open; // see [R5]
    wire ev_clear = ref_wr & ~bit_access & key_ok & (~first_done_ff | win_open); // see [R9]
    wire ev_ovf   = running & tick & at_last & ~ev_clear;               // see [R6] [R11]

    wwdt_pkg::wwdt_verdict_t verdict;
    assign verdict = (ev_bit | ev_key | ev_win | ev_ovf) ? wwdt_pkg::VD_FAULT :
                     ev_clear ? wwdt_pkg::VD_CLEAR : wwdt_pkg::VD_NONE;

    // Counter next value
    wire [CNT_W-1:0] cnt_inc = cnt_ff + {{(CNT_W - 1){1'b0}}, 1'b1};
    logic [CNT_W-1:0] nxt_cnt;
    always_comb begin
        nxt_cnt = cnt_ff;
        case (verdict)
            wwdt_pkg::VD_CLEAR: nxt_cnt = {CNT_W{1'b0}};                // see [R4] [R10]
            wwdt_pkg::VD_FAULT: nxt_cnt = cnt_ff;
            wwdt_pkg::VD_NONE:  nxt_cnt = (running & tick) ? cnt_inc : cnt_ff; // see [R12]
            default:            nxt_cnt = cnt_ff;
        endcase
    end

    wire nxt_fault = fault_ff | (verdict == wwdt_pkg::VD_FAULT);
    wire nxt_first = first_done_ff | ref_wr;

    // Events
    logic [`WWDT_EV_W-1:0] ev_set;
    logic [`WWDT_EV_W-1:0] ev_status;
    logic [`WWDT_EV_W-1:0] ev_mask;
    logic                  irq_int;

    assign ev_set[`WWDT_EV_REFRESH]  = ev_clear & ~ev_bit;
    assign ev_set[`WWDT_EV_OVERFLOW] = ev_ovf;
    assign ev_set[`WWDT_EV_WINDOW]   = ev_win;
    assign ev_set[`WWDT_EV_BADKEY]   = ev_key;
    assign ev_set[`WWDT_EV_BITACC]   = ev_bit;

    wwdt_events #(
        .W (`WWDT_EV_W)
    ) u_events (
        .clk       (clk),
        .rst_n     (rst_n),
        .set_evt   (ev_set),
        .clr_wr    (sts_wr),
        .mask_wr   (msk_wr),
        .wdata     (pwdata[`WWDT_EV_W-1:0]),
        .status_ff (ev_status),
        .mask_ff   (ev_mask),
        .irq_ff    (irq_int)
    );

    // Read mux
    logic [31:0] cnt_word;
    always_comb begin
        cnt_word = `WWDT_RST_WORD;
        cnt_word[CNT_W-1:0] = cnt_ff;
        cnt_word[`WWDT_CNT_RUN_BIT] = running;
        cnt_word[`WWDT_CNT_FIRST_BIT] = first_done_ff;
    end

    wire [31:0] sts_word = {{(32 - `WWDT_EV_W){1'b0}}, ev_status};
    wire [31:0] msk_word = {{(32 - `WWDT_EV_W){1'b0}}, ev_mask};
    wire [31:0] opt_word = {24'h000000, option_ff};
    wire [31:0] rd_word  = hit_sts ? sts_word :
                           hit_msk ? msk_word :
                           hit_cnt ? cnt_word :
                           hit_opt ? opt_word : `WWDT_RST_WORD;

    wire [31:0] nxt_prdata  = (setup & ~pwrite) ? rd_word : prdata_ff;
    wire        nxt_pready  = setup;
    wire        nxt_pslverr = setup & bad_req;

    // Option byte capture after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            option_ff <= `WWDT_RST_OPTION;
        end else if (!opt_loaded_ff) begin
            option_ff <= option_byte_in;                                // see [R1]
        end
    end

    // Capture done flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_loaded_ff <= 1'b0;
        end else begin
            opt_loaded_ff <= 1'b1;
        end
    end

    // Watchdog counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= {CNT_W{1'b0}};                                    // see [R12]
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // First refresh write tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_done_ff <= 1'b0;                                      // see [R12]
        end else begin
            first_done_ff <= nxt_first;                                 // see [R9]
        end
    end

    // Sticky fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= nxt_fault;
        end
    end

    // APB read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= `WWDT_RST_WORD;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    // APB ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= nxt_pready;
        end
    end

    // APB error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Output registers
    logic internal_rst_ff;
    logic irq_ff;

    // Internal reset output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_rst_ff <= 1'b0;
        end else begin
            internal_rst_ff <= nxt_fault;                               // see [R5] [R6] [R7] [R8]
        end
    end

    // Interrupt output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irq_int;
        end
    end

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign irq          = irq_ff;
    assign internal_rst = internal_rst_ff;

endmodule

`default_nettype wire

// File: rtl/wwdt_cfg.svh
// Constants for the windowed watchdog timer
`ifndef WWDT_CFG_SVH
`define WWDT_CFG_SVH

// Register byte offsets
`define WWDT_OFS_REFRESH    12'h000
`define WWDT_OFS_STATUS     12'h004
`define WWDT_OFS_MASK       12'h008
`define WWDT_OFS_COUNT      12'h00C
`define WWDT_OFS_OPTION     12'h0C0

// Refresh key
`define WWDT_KEY            8'hAC

// Option byte fields
`define WWDT_EN_BIT         4
`define WWDT_OVF_HI         3
`define WWDT_OVF_LO         1
`define WWDT_WIN_HI         6
`define WWDT_WIN_LO         5

// Overflow time is 2^(BASE_EXP + select) slow clock ticks
`define WWDT_BASE_EXP       7

// Open span selections
`define WWDT_WIN_25         2'h0
`define WWDT_WIN_50         2'h1
`define WWDT_WIN_75         2'h2

// Event status bits
`define WWDT_EV_W           5
`define WWDT_EV_REFRESH     0
`define WWDT_EV_OVERFLOW    1
`define WWDT_EV_WINDOW      2
`define WWDT_EV_BADKEY      3
`define WWDT_EV_BITACC      4

// Count register readback fields
`define WWDT_CNT_RUN_BIT    16
`define WWDT_CNT_FIRST_BIT  17

// Reset values
`define WWDT_RST_OPTION     8'h00
`define WWDT_RST_WORD       32'h0000_0000
`define WWDT_RST_EV         5'h00

`endif

// File: rtl/wwdt_pkg.sv
// Types for the windowed watchdog timer
package wwdt_pkg;

    typedef enum logic [1:0] {
        VD_NONE  = 2'b00,
        VD_CLEAR = 2'b01,
        VD_FAULT = 2'b10
    } wwdt_verdict_t;

endpackage

// File: rtl/wwdt_sync.sv
// Three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none

module wwdt_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Asynchronous input
    input  wire logic async_in,
    // Filtered level and rising edge pulse
    output logic      level_ff,
    output logic      rise_ff
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    wire  agree = (s2_ff == s3_ff);
    wire  nxt_level = agree ? s2_ff : level_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
            rise_ff  <= 1'b0;
        end else begin
            s1_ff    <= async_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            level_ff <= nxt_level;
            rise_ff  <= nxt_level & ~level_ff;
        end
    end

endmodule

`default_nettype wire

// File: rtl/wwdt_events.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none

module wwdt_events #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Event pulses
    input  wire logic [W-1:0] set_evt,
    // Software access
    input  wire logic         clr_wr,
    input  wire logic         mask_wr,
    input  wire logic [W-1:0] wdata,
    // State
    output logic      [W-1:0] status_ff,
    output logic      [W-1:0] mask_ff,
    output logic              irq_ff
);

    wire [W-1:0] clr_bits   = clr_wr ? wdata : {W{1'b0}};
    wire [W-1:0] nxt_status = set_evt | (status_ff & ~clr_bits);
    wire [W-1:0] nxt_mask   = mask_wr ? wdata : mask_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= {W{1'b0}};
            mask_ff   <= {W{1'b0}};
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            irq_ff    <= |(nxt_status & nxt_mask);
        end
    end

endmodule

`default_nettype wire

// File: tb/wwdt_chk.sv
// Port-level assertion checker for the windowed watchdog timer
`include "wwdt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wwdt_chk #(
    parameter int CNT_W = 15
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    // Watchdog
    input wire logic        bit_access,
    input wire logic [7:0]  option_byte_in,
    input wire logic        irq,
    input wire logic        internal_rst
);
    wire logic ref_wr;
    wire logic bad_key;
    assign ref_wr = psel && penable && pready && pwrite && paddr == `WWDT_OFS_REFRESH
                    && option_byte_in[`WWDT_EN_BIT] && !internal_rst;
    assign bad_key = pwdata[7:0] != `WWDT_KEY || !pstrb[0];

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_bit_access_fault: assert property (ref_wr && bit_access |-> ##2 internal_rst)
        else $error("bit access gave no fault");
    a_bad_key_fault: assert property (ref_wr && bad_key |-> ##2 internal_rst)
        else $error("wrong key gave no fault");
    a_fault_held: assert property (internal_rst |=> internal_rst)
        else $error("internal reset dropped");
    a_fuse_off_quiet: assert property (!option_byte_in[`WWDT_EN_BIT] |-> !internal_rst)
        else $error("fault while disabled");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_reset_quiet: assert property ($rose(rst_n) |-> !internal_rst && !irq)
        else $error("outputs set after reset");
    a_open_key_safe: assert property (ref_wr && !bad_key && !bit_access && option_byte_in[6:5] == 2'h3
        |-> ##2 !internal_rst)
        else $error("good key faulted");

    c_bad_key: cover property (ref_wr && bad_key);
    c_bit_access: cover property (ref_wr && bit_access);
    c_fault: cover property ($rose(internal_rst));
endmodule

bind wwdt_top wwdt_chk #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .bit_access(bit_access),
    .option_byte_in(option_byte_in), .irq(irq), .internal_rst(internal_rst));
`default_nettype wire

// File: tb/test_windowed_watchdog_timer.sv
// Self-checking testbench for the windowed watchdog timer
`include "wwdt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module test_windowed_watchdog_timer;
    logic        clk, rst_n, psel, penable, pwrite, bit_access, pready, pslverr, irq, internal_rst, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  opt;
    logic [2:0]  sdiv = 3'h0;
    int          errors, cmp_count;

    wwdt_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_access(bit_access), .option_byte_in(opt), .slow_osc_clock(sdiv[2]), .irq(irq),
        .internal_rst(internal_rst));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) sdiv <= sdiv + 3'h1;

    task automatic summarize();
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic limit(input logic ok);
        if (!ok) begin
            fail("timeout");
            summarize();
        end
    endtask

    task automatic chk1(input logic g, input logic x);
        cmp_count++;
        if (g !== x) fail("flag mismatch");
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) fail("word mismatch");
    endtask

    // One APB transfer; read data and error land in rd and er
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                       input logic b);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        bit_access <= b;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        limit(n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        bit_access <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdw(input logic [11:0] a);
        apb(a, 1'b0, 32'h0, 4'hF, 1'b0);
    endtask

    task automatic wrw(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 4'hF, 1'b0);
    endtask

    task automatic reboot(input logic [7:0] o);
        rst_n <= 1'b0;
        opt <= o;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk1(irq | internal_rst, 1'b0);
    endtask

    task automatic t_regs();
        reboot(8'h10);
        rdw(`WWDT_OFS_STATUS);
        chk32(rd, `WWDT_RST_WORD);
        rdw(`WWDT_OFS_OPTION);
        chk32(rd, 32'h0000_0010);
        rdw(`WWDT_OFS_COUNT);
        chk32(rd & 32'h0003_0000, 32'h0001_0000);
        rdw(12'h010);
        chk1(er, 1'b1);
        wrw(`WWDT_OFS_OPTION, 32'h0000_0000);
        chk1(er, 1'b1);
    endtask

    task automatic t_window();
        int k;
        wrw(`WWDT_OFS_REFRESH, 32'h0000_00AC);
        repeat (2) @(posedge clk);
        chk1(internal_rst, 1'b0);
        rdw(`WWDT_OFS_STATUS);
        chk32(rd, 32'h0000_0001);
        chk1(irq, 1'b0);
        wrw(`WWDT_OFS_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk1(irq, 1'b1);
        wrw(`WWDT_OFS_STATUS, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk1(irq, 1'b0);
        k = 0;
        do begin
            rdw(`WWDT_OFS_COUNT);
            k++;
        end while (rd[14:0] < 15'h7E && k < 600);
        limit(k < 600);
        wrw(`WWDT_OFS_REFRESH, 32'h0000_00AC);
        repeat (2) @(posedge clk);
        chk1(internal_rst, 1'b0);
        rdw(`WWDT_OFS_COUNT);
        chk1(rd[14:0] < 15'h4, 1'b1);
        wrw(`WWDT_OFS_REFRESH, 32'h0000_00AC);
        repeat (2) @(posedge clk);
        chk1(internal_rst, 1'b1);
        rdw(`WWDT_OFS_STATUS);
        chk32(rd & 32'h0000_0004, 32'h0000_0004);
    endtask

    task automatic t_ovf(input logic [2:0] sel);
        int n;
        int lim;
        lim = 8 << (7 + sel);
        reboot({3'h3, 1'b1, sel, 1'b0});
        wrw(`WWDT_OFS_REFRESH, 32'h0000_00AC);
        n = 1;
        while (internal_rst !== 1'b1 && n < 2 * lim) begin
            @(posedge clk);
            n++;
        end
        limit(n < 2 * lim);
        chk1(n >= lim - 16 && n <= lim + 24, 1'b1);
        rdw(`WWDT_OFS_STATUS);
        chk32(rd & 32'h0000_0002, 32'h0000_0002);
    endtask

    task automatic t_faults();
        for (int i = 0; i < 3; i++) begin
            reboot(8'h70);
            apb(`WWDT_OFS_REFRESH, 1'b1, (i == 1) ? 32'h53 : 32'hAC, (i == 2) ? 4'hE : 4'hF, i == 0);
            repeat (2) @(posedge clk);
            chk1(internal_rst, 1'b1);
            rdw(`WWDT_OFS_STATUS);
            chk32(rd & 32'h0000_0018, (i == 0) ? 32'h0000_0010 : 32'h0000_0008);
        end
    endtask

    task automatic t_win();
        for (int w = 0; w < 4; w++) begin
            reboot({1'b0, 2'(w), 5'h10});
            wrw(`WWDT_OFS_REFRESH, 32'h0000_00AC);
            wrw(`WWDT_OFS_REFRESH, 32'h0000_00AC);
            repeat (2) @(posedge clk);
            chk1(internal_rst, w != 3);
        end
    endtask

    task automatic t_fuse();
        reboot(8'h00);
        wrw(`WWDT_OFS_REFRESH, 32'h0000_0053);
        repeat (1100) @(posedge clk);
        chk1(internal_rst, 1'b0);
        rdw(`WWDT_OFS_COUNT);
        chk32(rd & 32'h0001_7FFF, `WWDT_RST_WORD);
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        bit_access = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        opt = 8'h00;
        errors = 0;
        cmp_count = 0;
        t_regs();
        t_window();
        t_ovf(3'h0);
        t_ovf(3'h1);
        t_faults();
        t_win();
        t_fuse();
        summarize();
    end
endmodule
`default_nettype wire
